// ==== logic/usctl_params.svh ====
`ifndef USCTL_PARAMS_SVH
`define USCTL_PARAMS_SVH
// Register indices; byte address is four times the index
`define USCTL_IDX_CTRL      10'h0BA
`define USCTL_IDX_RSTAT     10'h0BB
`define USCTL_IDX_CFG       10'h0BC
`define USCTL_IDX_DATA      10'h0B6
// Control register field positions
`define USCTL_B_PEN         7
`define USCTL_B_PSH         6
`define USCTL_B_PSL         5
`define USCTL_B_CLH         4
`define USCTL_B_CLL         3
`define USCTL_B_ERR         2
`define USCTL_B_RBF         1
`define USCTL_B_TBE         0
// Configuration register field position
`define USCTL_B_TWO_STOP_BITS        7
// Reset values
`define USCTL_CTRL_RST      8'h01
`define USCTL_ZERO_RST      8'h00
// Timing: core clock, baud rate, oversampling
`define USCTL_CLK_HZ        20000000
`define USCTL_BAUD          9600
`define USCTL_OVS           16
`define USCTL_DIV           (`USCTL_CLK_HZ / (`USCTL_OVS * `USCTL_BAUD))
`define USCTL_HALF          4'h7
`define USCTL_MID           4'h8
`define USCTL_RESUME        4'hA
`define USCTL_LAST          4'hF
`endif

// ==== logic/usctl_pkg.sv ====
package usctl_pkg;
  // Transmit engine states
  typedef enum logic {TX_IDLE, TX_SHIFT} usctl_tx_e;
  // Receive engine states
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} usctl_rx_e;
endpackage : usctl_pkg

// ==== logic/usctl_top.sv ====
`timescale 1ns/1ps
`include "usctl_params.svh"
module usctl_top
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_receive_pin,
  output logic             serial_transmit_pin
);
  // Control bits and flags
  logic        parity_enable, parity_select_high, parity_select_low, char_length_high, char_length_low;
  logic        error_reg, receive_full_flag, transmit_empty_flag, two_stop_bits;
  logic        overrun_flag, framing_error_flag, parity_error_flag, line_break_flag;
  logic        received_ninth_bit, attention_mode, transmitting_indication, receive_activity_indication;
  logic [7:0]  transmit_buffer, receive_buffer;  // Buffer registers
  logic [31:0] prdata_reg;                       // Read data
  logic        pready_reg, pslverr_reg;          // Bus answer
  logic [15:0] div_cnt;                          // Oversample divider
  logic        tick;                             // Sixteen-per-bit enable
  logic        rx_s1, rx_s2;                     // Pin synchroniser
  usctl_pkg::usctl_tx_e tx_state;                // Transmit state
  usctl_pkg::usctl_rx_e rx_state;                // Receive state
  logic [12:0] transmit_shifter;                 // Outgoing frame, LSB first
  logic [3:0]  tx_cnt, tx_left, rx_cnt, rx_idx;  // Tick and bit counters
  logic        tx_pin_reg;                       // Transmit pin
  logic [10:0] receive_shifter;                  // Collected bits
  logic        smp_a, smp_b;                     // Earlier centre samples

  // Bus decode
  wire         acc       = psel & penable & ~pready_reg;
  wire  [9:0]  widx      = paddr[11:2];
  wire         hit_ctrl  = widx == `USCTL_IDX_CTRL;
  wire         hit_rstat = widx == `USCTL_IDX_RSTAT;
  wire         hit_cfg   = widx == `USCTL_IDX_CFG;
  wire         hit_data  = widx == `USCTL_IDX_DATA;
  wire         mapped    = hit_ctrl | hit_rstat | hit_cfg | hit_data;
  wire         wr_ctrl   = acc & pwrite & hit_ctrl;
  wire         wr_rstat  = acc & pwrite & hit_rstat;
  wire         wr_cfg    = acc & pwrite & hit_cfg;
  wire         wr_transmit_buffer   = acc & pwrite & hit_data;
  wire         rd_receive_buffer   = acc & ~pwrite & hit_data;
  wire         rd_rstat  = acc & ~pwrite & hit_rstat;
  wire  [7:0]  ctrl_val  = {parity_enable, parity_select_high, parity_select_low, char_length_high,
                            char_length_low, error_reg, receive_full_flag, transmit_empty_flag};
  wire  [7:0]  rstat_val = {overrun_flag, framing_error_flag, parity_error_flag, line_break_flag,
                            received_ninth_bit, attention_mode, transmitting_indication,
                            receive_activity_indication};
  wire  [7:0]  rd_val    = hit_ctrl ? ctrl_val : hit_rstat ? rstat_val :
                           hit_cfg ? {two_stop_bits, 7'h00} : hit_data ? receive_buffer : 8'h00;

  // Framing decode
  // length decode
  wire         nine      = char_length_high;
  wire         loopback  = char_length_high & char_length_low;
  // Seven data bits only outside loopback, which frames nine
  wire         seven     = ~char_length_high & char_length_low;
  wire  [3:0]  nbits     = nine ? 4'h9 : char_length_low ? 4'h7 : 4'h8;
  wire         par_on    = parity_enable & ~nine;
  wire  [7:0]  tx_data   = seven ? {1'b0, transmit_buffer[6:0]} : transmit_buffer;
  wire         tx_par    = parity_select_high ? ~parity_select_low : (^tx_data) ^ ~parity_select_low;
  wire  [8:0]  tx_word   = {nine & parity_select_low, tx_data};
  wire  [3:0]  tx_len    = 4'h2 + nbits + {3'h0, par_on} + {3'h0, two_stop_bits};
  wire         tx_load   = (tx_state == usctl_pkg::TX_IDLE) & ~transmit_empty_flag;
  wire         tx_end    = (tx_state == usctl_pkg::TX_SHIFT) & tick & (tx_cnt == `USCTL_LAST)
                           & (tx_left == 4'h1);

  // Frame image: start bit, data, optional parity, then ones
  logic [12:0] frame;
  always_comb
  begin
    frame = 13'h1FFF;
    frame[0] = 1'b0;
    // Slot after seven data bits is a stop unless parity fills it
    frame[9:1] = nine ? tx_word : seven ? {2'b11, tx_data[6:0]} : {1'b1, tx_data};
    if (par_on)
    begin
      frame[nbits + 4'h1] = tx_par;
    end
  end

  // Receive line selection
  // internal loop
  wire         rx_line   = loopback ? tx_pin_reg : rx_s2;
  wire  [3:0]  rx_tot    = nbits + {3'h0, par_on} + 4'h1;
  wire         maj       = (smp_a & smp_b) | (smp_a & rx_line) | (smp_b & rx_line);
  wire         rx_bit    = (rx_state == usctl_pkg::RX_BITS) & tick & (rx_cnt == 4'h9);
  wire         rx_done   = rx_bit & (rx_idx == rx_tot - 4'h1);
  wire  [7:0]  rx_data   = seven ? {1'b0, receive_shifter[6:0]} : receive_shifter[7:0];
  wire         rx_pbit   = receive_shifter[nbits];
  wire         rx_pgood  = parity_select_high ? (rx_pbit == ~parity_select_low)
                                              : (rx_pbit == ((^rx_data) ^ ~parity_select_low));
  wire  [10:0] nz_mask   = (11'h001 << rx_idx) - 11'h001;
  wire         all_zero  = ~|(receive_shifter & nz_mask);
  wire         ev_break  = rx_done & ~maj & all_zero;
  wire         ev_frame  = rx_done & ~maj & ~all_zero;
  wire         ev_par    = rx_done & par_on & ~rx_pgood;
  wire         ev_over   = rx_done & receive_full_flag;
  wire         ev_any    = ev_break | ev_frame | ev_par | ev_over;

  // APB answer: one wait state, error on unmapped address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg  <= acc;
      pslverr_reg <= acc & ~mapped;
      prdata_reg  <= (acc & ~pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end
  end

  // Software-written control bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {parity_enable, parity_select_high, parity_select_low, char_length_high, char_length_low} <= 5'h00;
      two_stop_bits   <= 1'b0;
      transmit_buffer <= `USCTL_ZERO_RST;
    end
    else
    begin
      // Writable control fields only; flags ignore writes
      if (wr_ctrl)
      begin
        {parity_enable, parity_select_high, parity_select_low, char_length_high, char_length_low} <=
          pwdata[`USCTL_B_PEN:`USCTL_B_CLL];
      end
      if (wr_cfg)
      begin
        two_stop_bits <= pwdata[`USCTL_B_TWO_STOP_BITS];
      end
      if (wr_transmit_buffer)
      begin
        transmit_buffer <= pwdata[7:0];
      end
    end
  end

  // Oversample divider and pin synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
      rx_s1   <= 1'b1;
      rx_s2   <= 1'b1;
    end
    else
    begin
      tick    <= div_cnt == 16'((`USCTL_DIV) - 1);
      div_cnt <= (div_cnt == 16'((`USCTL_DIV) - 1)) ? 16'h0000 : div_cnt + 16'h0001;
      rx_s1   <= serial_receive_pin;
      rx_s2   <= rx_s1;
    end
  end

  // Transmit engine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state                <= usctl_pkg::TX_IDLE;
      transmit_shifter        <= 13'h1FFF;
      tx_cnt                  <= 4'h0;
      tx_left                 <= 4'h0;
      tx_pin_reg              <= 1'b1;
      transmit_empty_flag     <= 1'b1;
      transmitting_indication <= 1'b0;
    end
    else
    begin
      // set on transfer wins over write
      transmit_empty_flag <= tx_load | (transmit_empty_flag & ~wr_transmit_buffer);
      transmitting_indication <= tx_load | (transmitting_indication & ~(tx_end & transmit_empty_flag));
      case (tx_state)
        usctl_pkg::TX_IDLE:
        begin
          // Idle line high; take buffered byte
          tx_pin_reg <= 1'b1;
          if (tx_load)
          begin
            transmit_shifter <= frame;
            tx_left          <= tx_len;
            tx_cnt           <= 4'h0;
            tx_state         <= usctl_pkg::TX_SHIFT;
          end
        end
        usctl_pkg::TX_SHIFT:
        begin
          // Each bit held for sixteen ticks
          tx_pin_reg <= transmit_shifter[0];
          if (tick)
          begin
            tx_cnt <= tx_cnt + 4'h1;
            if (tx_cnt == `USCTL_LAST)
            begin
              transmit_shifter <= {1'b1, transmit_shifter[12:1]};
              tx_left          <= tx_left - 4'h1;
              if (tx_left == 4'h1)
              begin
                tx_state <= usctl_pkg::TX_IDLE;
              end
            end
          end
        end
        default:
        begin
          tx_state <= usctl_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Receive engine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state        <= usctl_pkg::RX_IDLE;
      rx_cnt          <= 4'h0;
      rx_idx          <= 4'h0;
      smp_a           <= 1'b1;
      smp_b           <= 1'b1;
      receive_shifter <= 11'h000;
    end
    else
    begin
      case (rx_state)
        usctl_pkg::RX_IDLE:
        begin
          // Low level hints at a start bit
          rx_cnt <= 4'h0;
          rx_idx <= 4'h0;
          if (tick & ~rx_line)
          begin
            rx_state <= usctl_pkg::RX_START;
          end
        end
        usctl_pkg::RX_START:
        begin
          if (tick)
          begin
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == `USCTL_HALF)
            begin
              // Skip the rest of the start bit; first capture one bit later
              rx_cnt   <= `USCTL_RESUME;
              rx_state <= rx_line ? usctl_pkg::RX_IDLE : usctl_pkg::RX_BITS;
            end
          end
        end
        usctl_pkg::RX_BITS:
        begin
          // samples at counts seven, eight, nine
          if (tick)
          begin
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == 4'h7)
            begin
              smp_a <= rx_line;
            end
            if (rx_cnt == `USCTL_MID)
            begin
              smp_b <= rx_line;
            end
            if (rx_bit)
            begin
              receive_shifter[rx_idx] <= maj;
              rx_idx                  <= rx_idx + 4'h1;
              if (rx_done)
              begin
                rx_state <= usctl_pkg::RX_IDLE;
              end
            end
          end
        end
        default:
        begin
          rx_state <= usctl_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Receive buffer, status flags and attention
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      receive_buffer              <= `USCTL_ZERO_RST;
      receive_full_flag           <= 1'b0;
      received_ninth_bit          <= 1'b0;
      attention_mode              <= 1'b0;
      overrun_flag                <= 1'b0;
      framing_error_flag          <= 1'b0;
      parity_error_flag           <= 1'b0;
      line_break_flag             <= 1'b0;
      error_reg                   <= 1'b0;
      receive_activity_indication <= 1'b0;
    end
    else
    begin
      if (rx_done)
      begin
        receive_buffer <= rx_data;
      end
      receive_full_flag <= rx_done | (receive_full_flag & ~rd_receive_buffer);
      if (rx_done & nine)
      begin
        received_ninth_bit <= receive_shifter[8];
      end
      if (rx_done & nine & receive_shifter[8])
      begin
        attention_mode <= 1'b0;
      end
      else if (wr_rstat)
      begin
        attention_mode <= pwdata[2];
      end
      overrun_flag       <= ev_over  | (overrun_flag & ~rd_rstat);
      framing_error_flag <= ev_frame | (framing_error_flag & ~rd_rstat);
      parity_error_flag  <= ev_par   | (parity_error_flag & ~rd_rstat);
      line_break_flag    <= ev_break | (line_break_flag & ~rd_rstat);
      error_reg <= ev_any | (error_reg & ~rd_rstat);
      receive_activity_indication <= ev_frame | ev_break | (receive_activity_indication & ~rx_line);
    end
  end

  // Outputs straight from flops
  assign prdata              = prdata_reg;
  assign pready              = pready_reg;
  assign pslverr             = pslverr_reg;
  assign serial_transmit_pin = tx_pin_reg;

  // Checks
  property p_tbe_clr;
    @(posedge pclk) disable iff (!presetn) wr_transmit_buffer & ~tx_load |=> ~transmit_empty_flag;
  endproperty
  a_tbe_clr: assert property (p_tbe_clr) else $error("empty flag not cleared");
  property p_rbf_clr;
    @(posedge pclk) disable iff (!presetn) rd_receive_buffer & ~rx_done |=> ~receive_full_flag;
  endproperty
  a_rbf_clr: assert property (p_rbf_clr) else $error("full flag not cleared");
  property p_err;
    @(posedge pclk) disable iff (!presetn) (overrun_flag | framing_error_flag | parity_error_flag
      | line_break_flag) |-> error_reg;
  endproperty
  a_err: assert property (p_err) else $error("global error missing");
  property p_nopar9;
    @(posedge pclk) disable iff (!presetn) nine |-> ~par_on & ~ev_par;
  endproperty
  a_nopar9: assert property (p_nopar9) else $error("parity in nine-bit mode");
  property p_start;
    @(posedge pclk) disable iff (!presetn)
      (rx_state == usctl_pkg::RX_START) & tick & (rx_cnt == `USCTL_HALF) & rx_line |=> rx_state == usctl_pkg::RX_IDLE;
  endproperty
  a_start: assert property (p_start) else $error("false start accepted");
  property p_receive_activity_indication;
    @(posedge pclk) disable iff (!presetn) receive_activity_indication & rx_line & ~ev_frame & ~ev_break
      |=> ~receive_activity_indication;
  endproperty
  a_receive_activity_indication: assert property (p_receive_activity_indication) else $error("activity not cleared");
  property p_over;
    @(posedge pclk) disable iff (!presetn) rx_done & receive_full_flag |=> overrun_flag & error_reg;
  endproperty
  a_over: assert property (p_over) else $error("overrun missed");
  property p_idle;
    @(posedge pclk) disable iff (!presetn) ~transmitting_indication ##1 ~transmitting_indication |-> tx_pin_reg;
  endproperty
  a_idle: assert property (p_idle) else $error("line low while not sending");
endmodule : usctl_top

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "usctl_params.svh"
module testbench;
  localparam int BIT = 2080; // Clocks per serial bit
  logic        pclk;        // Bus clock
  logic        presetn;     // Active-low reset
  logic        psel;        // Bus select
  logic        penable;     // Access phase
  logic        pwrite;      // Direction
  logic [11:0] paddr;       // Byte address
  logic [31:0] pwdata;      // Write data
  logic [31:0] prdata;      // Read data
  logic        pready;      // Access end
  logic        pslverr;     // Bus error
  logic        rxd;         // Peer to block
  logic        txd;         // Block to peer
  int          bad_count;   // Mismatches
  int          checked;     // Comparisons
  logic [7:0]  rd;          // Last read byte
  logic        er;          // Last error response
  int          f;           // Frame count mark
  usctl_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_receive_pin(rxd), .serial_transmit_pin(txd));
  usctl_peer #(.BIT(BIT)) peer (.pclk(pclk), .tx_line(txd), .rx_line(rxd));
  // Clock at 20 MHz
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // One bus transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      bad_count++;
      $display("BAD %0t no bus answer", $time);
    end
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Masked byte comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk, input string what);
    checked++;
    if ((got & msk) !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // Read a register and compare
  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp, input logic [7:0] msk, input string what);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp, msk, what);
  endtask : rd_chk
  // Poll control until receive full, bounded
  task automatic wait_full();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `USCTL_IDX_CTRL, 8'h00);
      n++;
    end
    while (rd[1] !== 1'b1 && n < 20000);
    if (rd[1] !== 1'b1)
    begin
      bad_count++;
      $display("BAD %0t receive full never set", $time);
    end
  endtask : wait_full
  // Wait for a new captured frame, bounded
  task automatic wait_frame(input int mark);
    int n;
    n = 0;
    while (peer.frames == mark && n < 40000)
    begin
      @(posedge pclk);
      n++;
    end
    if (peer.frames == mark)
    begin
      bad_count++;
      $display("BAD %0t no frame seen by peer", $time);
    end
  endtask : wait_frame
  // Reset values and unmapped access
  task automatic t_reset();
    rd_chk(`USCTL_IDX_CTRL, 8'h01, 8'hFF, "ctrl reset");
    rd_chk(`USCTL_IDX_RSTAT, 8'h00, 8'hFF, "status reset");
    rd_chk(`USCTL_IDX_CFG, 8'h00, 8'hFF, "cfg reset");
    apb(1'b0, 10'h000, 8'h00);
    chk({7'h0, er}, 8'h01, 8'hFF, "unmapped");
    $display("test reset done");
  endtask : t_reset
  // Writable and read-only bits
  task automatic t_regs();
    apb(1'b1, `USCTL_IDX_CTRL, 8'hE7);
    rd_chk(`USCTL_IDX_CTRL, 8'hE1, 8'hFF, "ctrl rw");
    apb(1'b1, `USCTL_IDX_RSTAT, 8'hFF);
    rd_chk(`USCTL_IDX_RSTAT, 8'h04, 8'hFF, "status rw");
    apb(1'b1, `USCTL_IDX_CFG, 8'h80);
    rd_chk(`USCTL_IDX_CFG, 8'h80, 8'h80, "cfg rw");
    $display("test regs done");
  endtask : t_regs
  // Nine-bit loopback with attention cleared
  task automatic t_loop();
    apb(1'b1, `USCTL_IDX_CFG, 8'h00);
    apb(1'b1, `USCTL_IDX_CTRL, 8'h38);
    f = peer.frames;
    apb(1'b1, `USCTL_IDX_DATA, 8'hA5);
    rd_chk(`USCTL_IDX_CTRL, 8'h39, 8'hFF, "loaded");
    rd_chk(`USCTL_IDX_RSTAT, 8'h06, 8'h06, "sending");
    wait_full();
    chk(rd, 8'h3B, 8'hFF, "looped full");
    rd_chk(`USCTL_IDX_RSTAT, 8'h08, 8'hFC, "ninth");
    rd_chk(`USCTL_IDX_DATA, 8'hA5, 8'hFF, "loop data");
    rd_chk(`USCTL_IDX_CTRL, 8'h39, 8'hFF, "full cleared");
    wait_frame(f);
    chk(peer.cap[8:1], 8'hA5, 8'hFF, "pin data");
    chk({5'h0, peer.cap[10:9], peer.cap[0]}, 8'h06, 8'hFF, "pin ninth");
    rd_chk(`USCTL_IDX_RSTAT, 8'h00, 8'h02, "tx idle");
    $display("test loop done");
  endtask : t_loop
  // Seven-bit even parity, two stops, back to back, parity error in
  task automatic t_duplex();
    apb(1'b1, `USCTL_IDX_CFG, 8'h80);
    apb(1'b1, `USCTL_IDX_CTRL, 8'hA8);
    f = peer.frames;
    apb(1'b1, `USCTL_IDX_DATA, 8'h55);
    fork
      peer.send(16'h0226, 10);
    join_none
    apb(1'b1, `USCTL_IDX_DATA, 8'h7F);
    rd_chk(`USCTL_IDX_CTRL, 8'h00, 8'h01, "buffer held");
    wait_full();
    chk(rd, 8'h06, 8'h06, "error full");
    rd_chk(`USCTL_IDX_RSTAT, 8'h20, 8'hF0, "parity");
    rd_chk(`USCTL_IDX_RSTAT, 8'h00, 8'hF0, "read cleared");
    rd_chk(`USCTL_IDX_CTRL, 8'h02, 8'h06, "error cleared");
    rd_chk(`USCTL_IDX_DATA, 8'h13, 8'hFF, "rx data");
    wait_frame(f);
    chk({1'b0, peer.cap[7:1]}, 8'h55, 8'hFF, "tx data");
    chk({4'h0, peer.cap[11:8]}, 8'h06, 8'hFF, "tx tail");
    $display("test duplex done");
  endtask : t_duplex
  // Line break and receive activity
  task automatic t_break();
    fork
      peer.send(16'h0000, 12);
    join_none
    repeat (11 * BIT) @(posedge pclk);
    rd_chk(`USCTL_IDX_CTRL, 8'h04, 8'h04, "break error");
    rd_chk(`USCTL_IDX_RSTAT, 8'h11, 8'hD1, "break");
    rd_chk(`USCTL_IDX_RSTAT, 8'h01, 8'hD1, "line low");
    repeat (2 * BIT) @(posedge pclk);
    rd_chk(`USCTL_IDX_RSTAT, 8'h00, 8'h01, "line high");
    $display("test break done");
  endtask : t_break
  // Counts, verdict, end of run
  task automatic close_out();
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  // Main sequence
  initial
  begin
    bad_count = 0;
    checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_loop();
    t_duplex();
    t_break();
    close_out();
  end
  // Watchdog against a hang
  initial
  begin
    // About 92000 clocks; the tests need roughly 76000
    #4600000;
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end
endmodule : testbench

// ==== tb/usctl_peer.sv ====
`timescale 1ns/1ps
// Remote serial peer: captures frames from the block, sends frames to it
module usctl_peer #(parameter int BIT = 2080)
(
  input  wire logic pclk,
  input  wire logic tx_line,
  output logic      rx_line
);
  logic [11:0] cap;    // Mid-bit samples, start bit first
  int          frames; // Frames captured so far
  // Idle line sits high between frames
  initial rx_line = 1'b1;
  // frame seen LSB first after start
  initial
  begin
    frames = 0;
    forever
    begin
      @(negedge tx_line);
      repeat (BIT / 2) @(posedge pclk);
      for (int i = 0; i < 12; i++)
      begin
        cap[i] = tx_line;
        if (i < 11)
          repeat (BIT) @(posedge pclk);
      end
      frames++;
    end
  end
  // start bit held a whole bit time
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      rx_line <= bits[i];
      repeat (BIT) @(posedge pclk);
    end
    rx_line <= 1'b1;
  endtask : send
endmodule : usctl_peer
